// File: design/ifd_pkg.sv
// Package with constants, field layouts and types of the auxiliary divider word decoder.
package ifd_pkg;

  // ==========================================================================
  // Serial word framing
  // ==========================================================================
  localparam int WORD_W = 24;
  localparam int CTL_W = 4;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
  localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;
  localparam logic [CNT_W-1:0] CNT_FULL = 5'h18;

  // Control codes in the low nibble that route a word to its register.
  localparam logic [CTL_W-1:0] CTL_WORD0 = 4'h0;
  localparam logic [CTL_W-1:0] CTL_WORD2 = 4'h5;
  localparam logic [CTL_W-1:0] CTL_WORD3 = 4'h6;
  localparam logic [CTL_W-1:0] CTL_WORD4 = 4'h9;
  localparam logic [CTL_W-1:0] CTL_WORD5 = 4'hB;
  localparam logic [CTL_W-1:0] CTL_WORD6 = 4'hD;
  localparam logic [CTL_W-1:0] CTL_WORD7 = 4'hF;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int AUX_PD_BIT = 23;
  localparam int AUX_N_MSB = 22;
  localparam int AUX_N_LSB = 4;
  localparam int AUX_N_W = 19;
  localparam int SWALLOW_W = 4;
  localparam int COARSE_W = 15;
  localparam int ACC_MSB = 23;
  localparam int ACC_LSB = 20;
  localparam int GAIN_MSB = 19;
  localparam int GAIN_LSB = 16;
  localparam int AUX_R_MSB = 15;
  localparam int AUX_R_LSB = 4;
  localparam int AUX_R_W = 12;
  localparam int AUTO_PU_BIT = 23;

  // Access field bits: bit 0 must be one, bits 1 to 3 enable words 5 to 7.
  localparam int ACC_W5 = 1;
  localparam int ACC_W6 = 2;
  localparam int ACC_W7 = 3;

  // ==========================================================================
  // Reset and default contents
  // ==========================================================================
  localparam logic [WORD_W-1:0] DIV_WORD_RST = 24'h000005;
  localparam logic [WORD_W-1:0] ACC_WORD_RST = 24'h000006;
  localparam logic [WORD_W-1:0] WORD5_DEF = 24'h00000B;
  localparam logic [WORD_W-1:0] WORD6_DEF = 24'h00000D;
  localparam logic [WORD_W-1:0] WORD7_DEF = 24'h00240F;

  typedef struct packed {
    logic [COARSE_W-1:0] coarse;
    logic [SWALLOW_W-1:0] swallow;
  } ifd_divider_t;

  typedef struct packed {
    logic loop_on;
    ifd_divider_t divider;
    logic [AUX_R_W-1:0] ref_div;
    logic [3:0] pump_gain;
  } ifd_aux_cfg_t;

endpackage

// File: design/ifd_sync.sv
// Three-stage synchroniser for pin inputs with an agreement filter.
`timescale 1ns/10ps
module ifd_sync
  import ifd_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic pin,
  output logic level
);

  logic s1_ff;
  logic s2_ff;
  logic s3_ff;
  logic level_ff;
  logic nxt_level;

  // A change counts only once the second and third stages agree.
  assign nxt_level = (s2_ff == s3_ff) ? s2_ff : level_ff;
  assign level = level_ff;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
      level_ff <= 1'b0;
    end else begin
      s1_ff <= pin;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      level_ff <= nxt_level;
    end
  end

endmodule

// File: design/ifd_shift.sv
// Serial shift register that frames 24-bit control words, MSB first.
`timescale 1ns/10ps
module ifd_shift
  import ifd_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic clk_rise,
  input wire logic data_in,
  input wire logic le_rise,
  output logic [WORD_W-1:0] word,
  output logic word_valid
);

  logic [WORD_W-1:0] sr_ff;
  logic [CNT_W-1:0] cnt_ff;
  logic valid_ff;
  logic [WORD_W-1:0] nxt_sr;
  logic [CNT_W-1:0] nxt_cnt;
  logic cnt_full;

  assign cnt_full = (cnt_ff >= CNT_FULL);
  assign nxt_sr = clk_rise ? {sr_ff[WORD_W-2:0], data_in} : sr_ff;
  // The count saturates so an over-long frame keeps only its last 24 bits.
  assign nxt_cnt = le_rise ? CNT_ZERO :
                   (clk_rise && !cnt_full) ? cnt_ff + CNT_ONE : cnt_ff;
  assign word = sr_ff;
  assign word_valid = valid_ff;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sr_ff <= '0;
      cnt_ff <= CNT_ZERO;
      valid_ff <= 1'b0;
    end else begin
      sr_ff <= nxt_sr;
      cnt_ff <= nxt_cnt;
      // Short frames are dropped rather than applied half-filled.
      valid_ff <= le_rise && cnt_full;
    end
  end

endmodule

// File: design/ifd_access_words.sv
// Decoder of the auxiliary divider word and the reference/access word.
// Summary of operation
// (RULE1) Power-down bit 23 set powers aux loop down, pump output tristated.
// (RULE2) With auto-powerup set, writing word zero clears the power-down bit.
// (RULE3) Chip-enable pin low keeps aux loop powered down regardless.
// (RULE4) Divider word, code 0101, carries aux feedback divide in bits 22..4.
// (RULE5) Host avoids divide values 23 or below with the 8/9 prescaler.
// (RULE6) With 8/9, only listed values in 24..55 are legal; 56 up all legal.
// (RULE7) 8/9 divider: coarse count in upper fifteen bits, swallow in low four.
// (RULE8) Host avoids divide values 47 or below with the 16/17 prescaler.
// (RULE9) With 16/17, only listed values in 48..239 are legal.
// (RULE10) 16/17: 240..524287 legal; swallow low four bits, coarse upper fifteen.
// (RULE11) Access word, code 0110, carries 12-bit reference divide in bits 15..4.
// (RULE12) Main pump gain comes from access word bits 19..16.
// (RULE13) Host programs words zero to four after power-up.
// (RULE14) Access bits 23..20 mark optional words five to seven programmable.
// (RULE15) Optional words in default mode are forced to default contents.
// (RULE16) Words shift in MSB first and apply on latch strobe rising.
`timescale 1ns/10ps
module ifd_access_words
  import ifd_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic ser_clk,
  input wire logic ser_data,
  input wire logic ser_latch,
  input wire logic chip_en,
  output logic aux_loop_on,
  output logic aux_pump_oe,
  output logic [COARSE_W-1:0] aux_coarse,
  output logic [SWALLOW_W-1:0] aux_swallow,
  output logic [AUX_R_W-1:0] aux_ref_div,
  output logic [3:0] main_pump_gain,
  output logic [WORD_W-1:0] word5_eff,
  output logic [WORD_W-1:0] word6_eff,
  output logic [WORD_W-1:0] word7_eff
);

  // ==========================================================================
  // Pin synchronisation and edge detection
  // ==========================================================================
  logic clk_lvl;
  logic data_lvl;
  logic latch_lvl;
  logic ce_lvl;
  logic clk_prev_ff;
  logic latch_prev_ff;
  logic clk_rise;
  logic latch_rise;

  ifd_sync u_sync_clk (.mclk(mclk), .rst(rst), .pin(ser_clk), .level(clk_lvl));
  ifd_sync u_sync_data (.mclk(mclk), .rst(rst), .pin(ser_data), .level(data_lvl));
  ifd_sync u_sync_latch (.mclk(mclk), .rst(rst), .pin(ser_latch), .level(latch_lvl));
  ifd_sync u_sync_ce (.mclk(mclk), .rst(rst), .pin(chip_en), .level(ce_lvl));

  assign clk_rise = clk_lvl && !clk_prev_ff;
  // (RULE16) Latch strobe edge.
  assign latch_rise = latch_lvl && !latch_prev_ff;

  // ==========================================================================
  // Word framing
  // ==========================================================================
  logic [WORD_W-1:0] word;
  logic word_valid;

  // (RULE16) Serial MSB-first shift.
  ifd_shift u_shift (
    .mclk(mclk),
    .rst(rst),
    .clk_rise(clk_rise),
    .data_in(data_lvl),
    .le_rise(latch_rise),
    .word(word),
    .word_valid(word_valid)
  );

  // ==========================================================================
  // Word routing by control code
  // ==========================================================================
  logic wr_w0;
  logic wr_w2;
  logic wr_w3;
  logic wr_w4;
  logic wr_w5;
  logic wr_w6;
  logic wr_w7;

  function automatic logic is_code(input logic [WORD_W-1:0] w, input logic [CTL_W-1:0] c);
    is_code = (w[CTL_W-1:0] == c);
  endfunction

  // (RULE16) Low nibble routing.
  assign wr_w0 = word_valid && is_code(word, CTL_WORD0);
  // (RULE4) Divider word code.
  assign wr_w2 = word_valid && is_code(word, CTL_WORD2);
  // (RULE11) Access word code.
  assign wr_w3 = word_valid && is_code(word, CTL_WORD3);
  assign wr_w4 = word_valid && is_code(word, CTL_WORD4);
  assign wr_w5 = word_valid && is_code(word, CTL_WORD5);
  assign wr_w6 = word_valid && is_code(word, CTL_WORD6);
  assign wr_w7 = word_valid && is_code(word, CTL_WORD7);

  // ==========================================================================
  // Stored words
  // ==========================================================================
  logic [WORD_W-1:0] div_word_ff;
  logic [WORD_W-1:0] acc_word_ff;
  logic [WORD_W-1:0] w5_ff;
  logic [WORD_W-1:0] w6_ff;
  logic [WORD_W-1:0] w7_ff;
  logic auto_pu_ff;
  logic [WORD_W-1:0] nxt_div_word;
  logic clr_pd;

  // Auto-powerup lives in word four; only that bit is kept here.
  // (RULE2) Word zero clears the power-down bit when auto-powerup is set.
  assign clr_pd = wr_w0 && auto_pu_ff;

  always_comb begin
    nxt_div_word = div_word_ff;
    if (wr_w2) begin
      nxt_div_word = word;
    end
    if (clr_pd) begin
      nxt_div_word[AUX_PD_BIT] = 1'b0;
    end
  end

  // Edge detectors reset low, the idle level of both pins, so reset makes no false edge.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      clk_prev_ff <= 1'b0;
      latch_prev_ff <= 1'b0;
    end else begin
      clk_prev_ff <= clk_lvl;
      latch_prev_ff <= latch_lvl;
    end
  end

  // (RULE4) Divider word store.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      div_word_ff <= DIV_WORD_RST;
    end else begin
      div_word_ff <= nxt_div_word;
    end
  end

  // (RULE11) Access word store.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      acc_word_ff <= ACC_WORD_RST;
    end else if (wr_w3) begin
      acc_word_ff <= word;
    end
  end

  // (RULE2) Auto-powerup setting.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      auto_pu_ff <= 1'b0;
    end else if (wr_w4) begin
      auto_pu_ff <= word[AUTO_PU_BIT];
    end
  end

  // (RULE14) Optional word stores, kept even while their outputs read default.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      w5_ff <= WORD5_DEF;
    end else if (wr_w5) begin
      w5_ff <= word;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      w6_ff <= WORD6_DEF;
    end else if (wr_w6) begin
      w6_ff <= word;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      w7_ff <= WORD7_DEF;
    end else if (wr_w7) begin
      w7_ff <= word;
    end
  end

  // ==========================================================================
  // Field decode
  // ==========================================================================
  logic [AUX_N_W-1:0] aux_n;
  logic [ACC_MSB-ACC_LSB:0] access;
  ifd_aux_cfg_t cfg;

  // (RULE4) Divide value from bits 22..4.
  assign aux_n = div_word_ff[AUX_N_MSB:AUX_N_LSB];
  assign access = acc_word_ff[ACC_MSB:ACC_LSB];

  // The same packing serves both prescalers, so the prescaler setting need not
  // be known here; legality of the value is left to the host.
  // (RULE7) Coarse upper fifteen, swallow lower four.
  // (RULE10) Same split with the wider prescaler.
  assign cfg.divider = ifd_divider_t'(aux_n);
  // (RULE11) Reference divide bits 15..4.
  assign cfg.ref_div = acc_word_ff[AUX_R_MSB:AUX_R_LSB];
  // (RULE12) Pump gain bits 19..16.
  assign cfg.pump_gain = acc_word_ff[GAIN_MSB:GAIN_LSB];
  // (RULE1) Power-down bit; (RULE3) chip enable low overrides it.
  assign cfg.loop_on = ce_lvl && !div_word_ff[AUX_PD_BIT];

  // ==========================================================================
  // Optional words and registered outputs
  // ==========================================================================
  logic [WORD_W-1:0] nxt_w5;
  logic [WORD_W-1:0] nxt_w6;
  logic [WORD_W-1:0] nxt_w7;

  // A word in default mode reads its default contents, whatever was stored.
  function automatic logic [WORD_W-1:0] opt_word(input logic prog,
      input logic [WORD_W-1:0] stored, input logic [WORD_W-1:0] dflt);
    opt_word = prog ? stored : dflt;
  endfunction

  // (RULE14) Access bits select programmable words.
  // (RULE15) Default-mode words forced to defaults.
  assign nxt_w5 = opt_word(access[ACC_W5], w5_ff, WORD5_DEF);
  assign nxt_w6 = opt_word(access[ACC_W6], w6_ff, WORD6_DEF);
  assign nxt_w7 = opt_word(access[ACC_W7], w7_ff, WORD7_DEF);

  // (RULE1) Loop power state.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      aux_loop_on <= 1'b0;
    end else begin
      aux_loop_on <= cfg.loop_on;
    end
  end

  // (RULE1) Pump drives only while the loop is on, so it floats when powered down.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      aux_pump_oe <= 1'b0;
    end else begin
      aux_pump_oe <= cfg.loop_on;
    end
  end

  // (RULE7) Coarse count output.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      aux_coarse <= '0;
    end else begin
      aux_coarse <= cfg.divider.coarse;
    end
  end

  // (RULE10) Swallow count output.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      aux_swallow <= '0;
    end else begin
      aux_swallow <= cfg.divider.swallow;
    end
  end

  // (RULE11) Reference divide output.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      aux_ref_div <= '0;
    end else begin
      aux_ref_div <= cfg.ref_div;
    end
  end

  // (RULE12) Main pump gain output.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      main_pump_gain <= '0;
    end else begin
      main_pump_gain <= cfg.pump_gain;
    end
  end

  // (RULE15) Effective optional words.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      word5_eff <= WORD5_DEF;
    end else begin
      word5_eff <= nxt_w5;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      word6_eff <= WORD6_DEF;
    end else begin
      word6_eff <= nxt_w6;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      word7_eff <= WORD7_DEF;
    end else begin
      word7_eff <= nxt_w7;
    end
  end

endmodule

// File: test/ifd_access_words_sva.sv
// Checker of the auxiliary divider word decoder outputs.
`timescale 1ns/10ps
module ifd_access_words_sva
  import ifd_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic ser_clk,
  input wire logic ser_data,
  input wire logic ser_latch,
  input wire logic chip_en,
  input wire logic aux_loop_on,
  input wire logic aux_pump_oe,
  input wire logic [COARSE_W-1:0] aux_coarse,
  input wire logic [SWALLOW_W-1:0] aux_swallow,
  input wire logic [AUX_R_W-1:0] aux_ref_div,
  input wire logic [3:0] main_pump_gain,
  input wire logic [WORD_W-1:0] word5_eff,
  input wire logic [WORD_W-1:0] word6_eff,
  input wire logic [WORD_W-1:0] word7_eff
);
  // ==========
  // Cycles since the last latch strobe rise, saturating.
  logic lat_q_ff;
  logic [4:0] quiet_ff;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      lat_q_ff <= 1'b0;
      quiet_ff <= 5'h00;
    end else begin
      lat_q_ff <= ser_latch;
      quiet_ff <= (ser_latch && !lat_q_ff) ? 5'h00 : quiet_ff + {4'h0, quiet_ff != 5'h1F};
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  sequence s_ce_drop;
    chip_en ##1 !chip_en [*8];
  endsequence

  AST_PUMP_OE_TRACKS: assert property (aux_pump_oe == aux_loop_on)
    else $error("pump enable differs from loop power");
  AST_CE_LOW_OFF: assert property (s_ce_drop |-> !aux_loop_on)
    else $error("loop powered while chip enable low");
  AST_RISE_NEEDS_CE: assert property ($rose(aux_loop_on) |-> chip_en && $past(chip_en, 3))
    else $error("loop powered up without chip enable");
  AST_FALL_HAS_CAUSE: assert property ($fell(aux_loop_on) |->
    !chip_en || (quiet_ff inside {[5'h03:5'h10]}))
    else $error("loop powered down without cause");
  AST_FIELDS_QUIET: assert property ((quiet_ff > 5'h14) |->
    $stable({aux_coarse, aux_swallow, aux_ref_div, main_pump_gain, word5_eff, word6_eff,
      word7_eff}))
    else $error("fields changed without a latch strobe");
  AST_FIELDS_AFTER_LATCH: assert property (
    $changed({aux_coarse, aux_swallow, aux_ref_div, main_pump_gain})
    |-> quiet_ff inside {[5'h03:5'h10]})
    else $error("divider fields changed out of time");
  AST_OPT_AFTER_LATCH: assert property ($changed({word5_eff, word6_eff, word7_eff})
    |-> quiet_ff inside {[5'h03:5'h10]})
    else $error("optional words changed out of time");
  AST_OPT_CODES: assert property (word5_eff[3:0] == CTL_WORD5 &&
    word6_eff[3:0] == CTL_WORD6 && word7_eff[3:0] == CTL_WORD7)
    else $error("optional word code field wrong");
endmodule

bind ifd_access_words ifd_access_words_sva sva (.mclk(mclk), .rst(rst), .ser_clk(ser_clk),
  .ser_data(ser_data), .ser_latch(ser_latch), .chip_en(chip_en), .aux_loop_on(aux_loop_on),
  .aux_pump_oe(aux_pump_oe), .aux_coarse(aux_coarse), .aux_swallow(aux_swallow),
  .aux_ref_div(aux_ref_div), .main_pump_gain(main_pump_gain), .word5_eff(word5_eff),
  .word6_eff(word6_eff), .word7_eff(word7_eff));

// File: test/ifd_host_model.sv
// Behavioural host that writes control words over the three-wire serial port.
`timescale 1ns/10ps
module ifd_host_model (
  input wire logic mclk,
  output logic ser_clk,
  output logic ser_data,
  output logic ser_latch
);
  initial begin
    ser_clk = 1'b0;
    ser_data = 1'b0;
    ser_latch = 1'b0;
  end

  // MSB first frame.
  // Each clock and latch level is held hc cycles, each data bit 2*hc; a short n is only used to provoke a drop.
  task automatic send(input logic [23:0] w, input int n, input int hc);
    for (int i = n - 1; i >= 0; i--) begin
      ser_data <= w[i];
      repeat (hc) @(posedge mclk);
      ser_clk <= 1'b1;
      repeat (hc) @(posedge mclk);
      ser_clk <= 1'b0;
    end
    // Released data line shows the inverse so no stale bit looks valid.
    ser_data <= ~w[0];
    repeat (hc) @(posedge mclk);
    ser_latch <= 1'b1;
    repeat (hc) @(posedge mclk);
    ser_latch <= 1'b0;
    repeat (hc) @(posedge mclk);
  endtask
endmodule

// File: test/ifd_access_words_tb.sv
// Self-checking bench of the auxiliary divider word decoder.
`timescale 1ns/10ps
module ifd_access_words_tb
  import ifd_pkg::*;
;
  logic mclk, rst, chip_en, ser_clk, ser_data, ser_latch, aux_loop_on, aux_pump_oe;
  logic [COARSE_W-1:0] aux_coarse;
  logic [SWALLOW_W-1:0] aux_swallow;
  logic [AUX_R_W-1:0] aux_ref_div;
  logic [3:0] main_pump_gain;
  logic [WORD_W-1:0] word5_eff, word6_eff, word7_eff;
  int failures = 0;
  int samples_checked = 0;
  int cycles = 0;
  // legal divide fields for the 8/9 prescaler, swallow 0 to 7.
  logic [18:0] dv [5] = '{19'h00030, 19'h00070, 19'h000F0, 19'h7FFF7, 19'h00347};

  ifd_access_words dut (.mclk(mclk), .rst(rst), .ser_clk(ser_clk), .ser_data(ser_data),
    .ser_latch(ser_latch), .chip_en(chip_en), .aux_loop_on(aux_loop_on),
    .aux_pump_oe(aux_pump_oe), .aux_coarse(aux_coarse), .aux_swallow(aux_swallow),
    .aux_ref_div(aux_ref_div), .main_pump_gain(main_pump_gain), .word5_eff(word5_eff),
    .word6_eff(word6_eff), .word7_eff(word7_eff));
  ifd_host_model host (.mclk(mclk), .ser_clk(ser_clk), .ser_data(ser_data),
    .ser_latch(ser_latch));

  // ==========
  task automatic chk(input string nm, input logic [23:0] got, input logic [23:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [23:0] w);
    @(posedge mclk);
    host.send(w, 24, 4);
    repeat (12) @(posedge mclk);
  endtask

  task automatic close_out();
    if (failures == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // A run of 29 frames needs well under this ceiling.
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 30000) begin
      failures++;
      close_out();
    end
  end

  // ==========
  initial begin
    rst = 1'b1;
    chip_en = 1'b1;
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    repeat (2) @(posedge mclk);
    chk("w5", word5_eff, WORD5_DEF);
    chk("w7", word7_eff, WORD7_DEF);
    // all five words zero to four before relying on outputs.
    wr(24'h000000);
    wr(24'h000003);
    wr({1'b0, 19'h00070, CTL_WORD2});
    wr({4'h1, 4'h0, 12'h003, CTL_WORD3});
    wr(24'h000009);
    foreach (dv[i]) begin
      wr({1'b0, dv[i], CTL_WORD2});
      chk("coarse", 24'(aux_coarse), 24'(dv[i][18:4]));
      chk("swallow", 24'(aux_swallow), 24'(dv[i][3:0]));
      chk("loop", 24'({aux_loop_on, aux_pump_oe}), 24'h3);
    end
    wr({1'b1, 19'h00070, CTL_WORD2});
    wr(24'h800009);
    chk("pd", 24'({aux_loop_on, aux_pump_oe}), 24'h0);
    wr(24'h000000);
    chk("autopu", 24'({aux_loop_on, aux_pump_oe}), 24'h3);
    wr(24'h000009);
    wr({1'b1, 19'h00070, CTL_WORD2});
    wr(24'h000000);
    chk("noauto", 24'(aux_loop_on), 24'h0);
    wr({1'b0, 19'h00070, CTL_WORD2});
    chip_en <= 1'b0;
    wr({1'b0, 19'h00070, CTL_WORD2});
    chk("celow", 24'({aux_loop_on, aux_pump_oe}), 24'h0);
    chip_en <= 1'b1;
    repeat (10) @(posedge mclk);
    chk("cehigh", 24'(aux_loop_on), 24'h1);
    wr({4'h3, 4'hF, 12'h003, CTL_WORD3});
    chk("gain", 24'(main_pump_gain), 24'hF);
    chk("ref", 24'(aux_ref_div), 24'h003);
    wr(24'hABCDEB);
    wr(24'h12345D);
    chk("w5", word5_eff, 24'hABCDEB);
    chk("w6", word6_eff, WORD6_DEF);
    wr({4'hF, 4'h0, 12'hFFF, CTL_WORD3});
    chk("w6", word6_eff, 24'h12345D);
    chk("ref", 24'(aux_ref_div), 24'hFFF);
    chk("gain", 24'(main_pump_gain), 24'h0);
    wr(24'h55555F);
    chk("w7", word7_eff, 24'h55555F);
    wr({4'h1, 4'h5, 12'h0A5, CTL_WORD3});
    chk("w7", word7_eff, WORD7_DEF);
    chk("w5", word5_eff, WORD5_DEF);
    host.send({1'b0, 19'h12345, CTL_WORD2}, 16, 4);
    repeat (12) @(posedge mclk);
    chk("short", 24'(aux_coarse), 24'h7);
    host.send({1'b0, 19'h000F0, CTL_WORD2}, 24, 10);
    repeat (12) @(posedge mclk);
    chk("slow", 24'(aux_coarse), 24'hF);
    // 16/17 prescaler selected, then only legal divide fields.
    wr(24'h000109);
    wr({1'b0, 19'h00033, CTL_WORD2});
    chk("swallow", 24'(aux_swallow), 24'h3);
    wr({1'b0, 19'h7FFFF, CTL_WORD2});
    chk("coarse", 24'(aux_coarse), 24'h7FFF);
    chk("swallow", 24'(aux_swallow), 24'hF);
    close_out();
  end
endmodule
